// ### design/sfb_loader.sv
// Bootloader record receiver, program writer and restart sequencer.
`default_nettype none
// Summary of operation
// - Byte 0x19 restarts the microcontroller
// - Window opens after every reset
// - Colon starts a new record while the window is open
// - Good record answered with Ok CR LF
// - Record data overwrites program memory
// - Silence ends window unless data was loaded
// - Disarm query answers U when unlocked
// - After load restart and restore interval
// - Every reply line ends CR LF
module sfb_loader #(
    parameter int unsigned WIN_CYC = sfb_pkg::WIN_CYC
) (
    // Clock, reset and enable.
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic               clk_en,
    // Lock switch, high when unlocked.
    input  wire logic               unlocked,
    // Received byte stream.
    input  wire logic               rx_valid,
    input  wire logic [7:0]         rx_data,
    output logic                    rx_ready,
    // Reply byte stream.
    output logic                    tx_valid,
    output logic [7:0]              tx_data,
    input  wire logic               tx_ready,
    // Program memory and system control.
    output sfb_pkg::sfb_pm_wr_s     pm_wr,
    output logic                    mcu_reset,
    output logic                    ivl_restore,
    output logic                    boot_open
);
    logic                rst_meta_r;      // First reset release stage.
    logic                rstn_s;          // Released reset for the design.
    sfb_pkg::sfb_state_e state_r;         // Sequencer state.
    sfb_pkg::sfb_rep_e   rep_r;           // Reply being sent.
    logic [1:0]          ridx_r;          // Reply character index.
    logic [8:0]          bidx_r;          // Byte index inside the record.
    logic [7:0]          len_r;           // Data byte count.
    logic [7:0]          type_r;          // Record type.
    logic [15:0]         addr_r;          // Load address.
    logic [7:0]          sum_r;           // Running checksum.
    logic                hi_r;            // High nibble held.
    logic [3:0]          hnib_r;          // Held high nibble.
    logic [7:0]          widx_r;          // Write index.
    logic [31:0]         tmr_r;           // Window silence counter.
    logic                loaded_r;        // Data written since last restart.
    logic [7:0]          dbuf [sfb_pkg::DATA_MAX];  // Record payload.
    logic                buf_ready_w;     // Reply buffer accepts.
    logic                take_w;          // A byte is consumed.
    logic                is_dig_w;        // Decimal digit.
    logic                is_uc_w;         // Upper case hex letter.
    logic                is_lc_w;         // Lower case hex letter.
    logic                hex_w;           // Any hex digit.
    logic [3:0]          nib_w;           // Nibble value.
    logic [7:0]          byte_w;          // Completed byte.
    logic                done_w;          // Byte completes now.
    logic                last_w;          // Completed byte is the checksum.
    logic                sum_ok_w;        // Record sums to zero.
    logic                good_w;          // Record accepted.
    logic                rst_cmd_w;       // Restart byte taken.
    logic                expire_w;        // Window ran out.
    logic                push_w;          // Reply char pushed.
    logic [7:0]          tx_char_w;       // Reply char.
    logic                lf_w;            // Reply char ends the line.
    sfb_pkg::sfb_state_e nxt_w;           // Next state.

    ////////////////////////////////////////////////////////////////////////////
    // Reset is released through two flops so no flop sees a ragged release.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rstn_s     <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rstn_s     <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Character decode.
    assign take_w    = rx_valid && rx_ready;
    assign is_dig_w  = rx_data >= 8'h30 && rx_data <= 8'h39;
    assign is_uc_w   = rx_data >= 8'h41 && rx_data <= 8'h46;
    assign is_lc_w   = rx_data >= 8'h61 && rx_data <= 8'h66;
    assign hex_w     = is_dig_w || is_uc_w || is_lc_w;
    assign nib_w     = is_dig_w ? rx_data[3:0] : 4'(rx_data[3:0] + 4'h9);
    assign byte_w    = {hnib_r, nib_w};
    assign done_w    = take_w && state_r == sfb_pkg::ST_HEX && hex_w && hi_r;
    assign last_w    = bidx_r == 9'({1'b0, len_r} + sfb_pkg::POS_DATA);
    assign sum_ok_w  = 8'(sum_r + byte_w) == 8'h00;
    // Checksum checked before program memory is written.
    assign good_w    = done_w && last_w && sum_ok_w && unlocked;
    assign rst_cmd_w = take_w && rx_data == sfb_pkg::CH_RESET;
    assign expire_w  = boot_open && tmr_r == WIN_CYC - 1;

    // Reply text; every line closes with CR then LF.
    assign tx_char_w = ridx_r == 2'd3 ? sfb_pkg::CH_LF :
                       ridx_r == 2'd2 ? sfb_pkg::CH_CR :
                       rep_r == sfb_pkg::REP_OK ?
                           (ridx_r == 2'd0 ? sfb_pkg::CH_O : sfb_pkg::CH_K) :
                       rep_r == sfb_pkg::REP_UNL ? sfb_pkg::CH_U : sfb_pkg::CH_L;
    assign push_w    = state_r == sfb_pkg::ST_REPLY && buf_ready_w;
    assign lf_w      = tx_char_w == sfb_pkg::CH_LF;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.  The restart byte wins over any partly received record.
    always_comb begin
        nxt_w = state_r;
        unique case (state_r)
            sfb_pkg::ST_HUNT: begin
                // Records only count while the window is open.
                if (take_w && rx_data == sfb_pkg::CH_COLON && boot_open) begin
                    nxt_w = sfb_pkg::ST_HEX;
                end else if (take_w && rx_data == sfb_pkg::CH_DISARM) begin
                    nxt_w = sfb_pkg::ST_REPLY;
                end
            end
            sfb_pkg::ST_HEX: begin
                if (take_w && !hex_w && rx_data != sfb_pkg::CH_COLON) begin
                    nxt_w = sfb_pkg::ST_HUNT;
                end else if (done_w && last_w) begin
                    if (!good_w) begin
                        nxt_w = sfb_pkg::ST_HUNT;
                    end else if (type_r == sfb_pkg::REC_DATA && len_r != 8'h00) begin
                        nxt_w = sfb_pkg::ST_WRITE;
                    end else begin
                        nxt_w = sfb_pkg::ST_REPLY;
                    end
                end
            end
            sfb_pkg::ST_WRITE: begin
                if (widx_r == 8'(len_r - 8'h01)) begin
                    nxt_w = sfb_pkg::ST_REPLY;
                end
            end
            sfb_pkg::ST_REPLY: begin
                if (push_w && lf_w) begin
                    nxt_w = sfb_pkg::ST_HUNT;
                end
            end
        endcase
        if (rst_cmd_w) begin
            nxt_w = sfb_pkg::ST_HUNT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer, input flow control and reply selection.
    always_ff @(posedge clock or negedge rstn_s) begin
        if (!rstn_s) begin
            state_r  <= sfb_pkg::ST_HUNT;
            rx_ready <= 1'b0;
            rep_r    <= sfb_pkg::REP_OK;
            ridx_r   <= 2'd0;
        end else if (clk_en) begin
            state_r  <= nxt_w;
            // Input stalls while writing or answering, as the host waits anyway.
            rx_ready <= nxt_w == sfb_pkg::ST_HUNT || nxt_w == sfb_pkg::ST_HEX;
            if (state_r != sfb_pkg::ST_REPLY) begin
                // Ok replies use all four slots, lock answers skip one.
                rep_r  <= state_r == sfb_pkg::ST_HUNT ?
                          (unlocked ? sfb_pkg::REP_UNL : sfb_pkg::REP_LCK) : sfb_pkg::REP_OK;
                ridx_r <= state_r == sfb_pkg::ST_HUNT ? 2'd1 : 2'd0;
            end else if (push_w) begin
                ridx_r <= ridx_r + 2'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Record field capture; a colon always restarts the byte count.
    always_ff @(posedge clock or negedge rstn_s) begin
        if (!rstn_s) begin
            bidx_r <= 9'h000;
            len_r  <= 8'h00;
            type_r <= 8'h00;
            addr_r <= 16'h0000;
            sum_r  <= 8'h00;
            hi_r   <= 1'b0;
            hnib_r <= 4'h0;
        end else if (clk_en && take_w) begin
            if (rx_data == sfb_pkg::CH_COLON) begin
                bidx_r <= 9'h000;
                len_r  <= 8'h00;
                sum_r  <= 8'h00;
                hi_r   <= 1'b0;
            end else if (hex_w && !hi_r) begin
                hnib_r <= nib_w;
                hi_r   <= 1'b1;
            end else if (done_w) begin
                hi_r   <= 1'b0;
                sum_r  <= 8'(sum_r + byte_w);
                bidx_r <= 9'(bidx_r + 9'h001);
                if (bidx_r == sfb_pkg::POS_LEN) len_r <= byte_w;
                if (bidx_r == sfb_pkg::POS_AHI) addr_r[15:8] <= byte_w;
                if (bidx_r == sfb_pkg::POS_ALO) addr_r[7:0] <= byte_w;
                if (bidx_r == sfb_pkg::POS_TYPE) type_r <= byte_w;
            end
        end
    end

    // Payload store; no reset needed since it is read only after filling.
    always_ff @(posedge clock) begin
        if (clk_en && done_w && bidx_r >= sfb_pkg::POS_DATA && !last_w) begin
            dbuf[8'(bidx_r - sfb_pkg::POS_DATA)] <= byte_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program memory writes, one byte a cycle, only after the checksum passed.
    always_ff @(posedge clock or negedge rstn_s) begin
        if (!rstn_s) begin
            pm_wr  <= '0;
            widx_r <= 8'h00;
        end else if (clk_en) begin
            pm_wr.en   <= state_r == sfb_pkg::ST_WRITE;
            pm_wr.addr <= 16'(addr_r + {8'h00, widx_r});
            pm_wr.data <= dbuf[widx_r];
            widx_r     <= state_r == sfb_pkg::ST_WRITE ? 8'(widx_r + 8'h01) : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Window timer and restart; a restart always reopens the window.
    always_ff @(posedge clock or negedge rstn_s) begin
        if (!rstn_s) begin
            boot_open   <= 1'b1;
            tmr_r       <= 32'h0000_0000;
            loaded_r    <= 1'b0;
            mcu_reset   <= 1'b0;
            ivl_restore <= 1'b0;
        end else if (clk_en) begin
            mcu_reset   <= rst_cmd_w || (expire_w && loaded_r);
            ivl_restore <= !rst_cmd_w && expire_w && loaded_r;
            if (rst_cmd_w || (expire_w && loaded_r)) begin
                boot_open <= 1'b1;
                tmr_r     <= 32'h0000_0000;
                loaded_r  <= 1'b0;
            end else if (expire_w) begin
                boot_open <= 1'b0;
            end else begin
                tmr_r    <= good_w ? 32'h0000_0000 : tmr_r + 32'h0000_0001;
                loaded_r <= loaded_r || pm_wr.en;
            end
        end
    end

    // Reply path buffer absorbs a stalled host.
    sfb_reply_buf u_buf (
        .clock     (clock),
        .rstn      (rstn_s),
        .clk_en    (clk_en),
        .in_valid  (push_w),
        .in_data   (tx_char_w),
        .in_ready  (buf_ready_w),
        .out_valid (tx_valid),
        .out_data  (tx_data),
        .out_ready (tx_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn_s || !clk_en);

    sequence s_good_rec;
        good_w && type_r == sfb_pkg::REC_DATA && len_r != 8'h00;
    endsequence

    property p_reset_byte;
        rst_cmd_w |=> mcu_reset && state_r == sfb_pkg::ST_HUNT;
    endproperty
    a_reset_byte: assert property (p_reset_byte) else $error("restart byte ignored");

    property p_win_reopen;
        mcu_reset |-> boot_open && tmr_r == 32'h0000_0000;
    endproperty
    a_win_reopen: assert property (p_win_reopen) else $error("window not reopened");

    property p_colon;
        take_w && rx_data == sfb_pkg::CH_COLON && boot_open && !rst_cmd_w
            && state_r != sfb_pkg::ST_REPLY |=> state_r == sfb_pkg::ST_HEX && bidx_r == 9'h000;
    endproperty
    a_colon: assert property (p_colon) else $error("colon did not start record");

    property p_ok_reply;
        push_w && rep_r == sfb_pkg::REP_OK && tx_char_w == sfb_pkg::CH_O
            |=> rep_r == sfb_pkg::REP_OK && ridx_r == 2'd1;
    endproperty
    a_ok_reply: assert property (p_ok_reply) else $error("ok reply broken");

    property p_crlf;
        push_w && tx_char_w == sfb_pkg::CH_CR |=> !push_w || tx_char_w == sfb_pkg::CH_LF;
    endproperty
    a_crlf: assert property (p_crlf) else $error("CR not followed by LF");

    property p_write;
        s_good_rec ##1 !rst_cmd_w |=> pm_wr.en && pm_wr.addr == addr_r;
    endproperty
    a_write: assert property (p_write) else $error("record not written");

    property p_bad_sum;
        done_w && last_w && !sum_ok_w && !rst_cmd_w |=> state_r == sfb_pkg::ST_HUNT;
    endproperty
    a_bad_sum: assert property (p_bad_sum) else $error("bad record acknowledged");

    property p_expire;
        expire_w && loaded_r && !rst_cmd_w |=> mcu_reset && ivl_restore;
    endproperty
    a_expire: assert property (p_expire) else $error("no restart on silence");

    property p_restore;
        ivl_restore |-> mcu_reset;
    endproperty
    a_restore: assert property (p_restore) else $error("restore without restart");

    property p_disarm;
        take_w && state_r == sfb_pkg::ST_HUNT && rx_data == sfb_pkg::CH_DISARM && unlocked
            |=> state_r == sfb_pkg::ST_REPLY && rep_r == sfb_pkg::REP_UNL;
    endproperty
    a_disarm: assert property (p_disarm) else $error("unlock answer wrong");
endmodule : sfb_loader
`default_nettype wire

// ### design/sfb_reply_buf.sv
// Two-entry reply buffer with valid and ready on both sides.
`default_nettype none
module sfb_reply_buf (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    // Filling side.
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    output logic            in_ready,
    // Draining side.
    output logic            out_valid,
    output logic [7:0]      out_data,
    input  wire logic       out_ready
);
    logic [7:0] skid_d_r;  // Second entry, used only while the drain stalls.
    logic       skid_v_r;  // Second entry holds a word.
    logic       drain_w;   // Head may be replaced this cycle.
    logic       push_w;    // A word is accepted this cycle.

    assign in_ready = !skid_v_r;
    assign drain_w  = out_ready || !out_valid;
    assign push_w   = in_valid && !skid_v_r;

    ////////////////////////////////////////////////////////////////////////////
    // The head stays registered so the port never sees a mux, at the cost of
    // one extra cycle of latency through the buffer.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            out_data  <= 8'h00;
            skid_v_r  <= 1'b0;
            skid_d_r  <= 8'h00;
        end else if (clk_en) begin
            if (drain_w) begin
                // Older word in the second entry always leaves first.
                if (skid_v_r) begin
                    out_data  <= skid_d_r;
                    out_valid <= 1'b1;
                    skid_v_r  <= 1'b0;
                end else begin
                    out_data  <= in_data;
                    out_valid <= push_w;
                end
            end else if (push_w) begin
                // Receiver stalls: park the word rather than lose it.
                skid_d_r <= in_data;
                skid_v_r <= 1'b1;
            end
        end
    end
endmodule : sfb_reply_buf
`default_nettype wire

// ### pkg/sfb_pkg.sv
// Constants, types and carriers shared by the serial firmware bootloader.
`default_nettype none
package sfb_pkg;
    // Characters seen on the byte link.
    localparam logic [7:0] CH_RESET  = 8'h19;  // Host request to restart the controller.
    localparam logic [7:0] CH_COLON  = 8'h3a;  // Start of a hex record.
    localparam logic [7:0] CH_DISARM = 8'h7a;  // Lock-state query.
    localparam logic [7:0] CH_CR     = 8'h0d;  // Carriage return.
    localparam logic [7:0] CH_LF     = 8'h0a;  // Line feed.
    localparam logic [7:0] CH_O      = 8'h4f;  // First acknowledge letter.
    localparam logic [7:0] CH_K      = 8'h6b;  // Second acknowledge letter.
    localparam logic [7:0] CH_U      = 8'h55;  // Unlocked answer.
    localparam logic [7:0] CH_L      = 8'h4c;  // Locked answer.
    // Record types that the loader knows.
    localparam logic [7:0] REC_DATA  = 8'h00;
    // Byte positions inside a record.
    localparam logic [8:0] POS_LEN   = 9'h000;
    localparam logic [8:0] POS_AHI   = 9'h001;
    localparam logic [8:0] POS_ALO   = 9'h002;
    localparam logic [8:0] POS_TYPE  = 9'h003;
    localparam logic [8:0] POS_DATA  = 9'h004;
    // Bootloader window timing.
    localparam int unsigned CLK_MHZ  = 200;
    localparam int unsigned WIN_MS   = 3000;
    localparam int unsigned WIN_CYC  = WIN_MS * 1000 * CLK_MHZ;
    localparam int unsigned DATA_MAX = 256;
    // Main sequencer states.
    typedef enum logic [1:0] {ST_HUNT, ST_HEX, ST_WRITE, ST_REPLY} sfb_state_e;
    // Kinds of text reply.
    typedef enum logic [1:0] {REP_OK, REP_UNL, REP_LCK} sfb_rep_e;
    // Program memory write beat.
    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [7:0]  data;
    } sfb_pm_wr_s;
endpackage : sfb_pkg
`default_nettype wire

// ### sim/serial_firmware_bootloader_tb_top.sv
// Self-checking bench for the bootloader record loader.
`default_nettype none
module serial_firmware_bootloader_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WIN = 200;  // Short window so expiry fits the run.
    logic                clock, resetn, clk_en, unlocked;
    logic                rx_valid, rx_ready, tx_valid, tx_ready;
    logic                mcu_reset, ivl_restore, boot_open;
    logic [7:0]          rx_data, tx_data;
    sfb_pkg::sfb_pm_wr_s pm_wr;
    int                  fails, checks, n_rst, n_ivl;
    logic [23:0]         wr[$];         // Program writes as address and data.
    ////////////////////////////////////////////////////////////////////////
    sfb_loader #(.WIN_CYC(WIN)) sfb_loader_i (.clock(clock), .resetn(resetn),
        .clk_en(clk_en), .unlocked(unlocked), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .pm_wr(pm_wr),
        .mcu_reset(mcu_reset), .ivl_restore(ivl_restore), .boot_open(boot_open));
    sfb_host_model sfb_host_model_i (.clock(clock), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    // Free-running 200 MHz clock.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Pulses and program writes are tallied at every rising edge.
    always @(posedge clock) begin
        if (mcu_reset === 1'b1) n_rst++;
        if (ivl_restore === 1'b1) n_ivl++;
        if (pm_wr.en === 1'b1) wr.push_back({pm_wr.addr, pm_wr.data});
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Waits for a whole reply, then a little longer so extra bytes show too.
    task automatic reply(input string s);
        int n;
        n = 0;
        while (sfb_host_model_i.got.size() < s.len() && n < 100) begin
            @(posedge clock);
            n++;
        end
        repeat (8) @(posedge clock);
        chk(sfb_host_model_i.got.size(), s.len());
        for (int i = 0; i < s.len(); i++) begin
            chk(sfb_host_model_i.got.pop_front(), s[i]);
        end
        sfb_host_model_i.got.delete();
    endtask : reply
    // The restart byte pulses the controller reset once, without a restore.
    task automatic t_restart();
        int r;
        int v;
        r = n_rst;
        v = n_ivl;
        sfb_host_model_i.put(sfb_pkg::CH_RESET);
        sfb_host_model_i.send("");
        repeat (4) @(posedge clock);
        chk(n_rst - r, 1);
        chk(n_ivl - v, 0);
        chk(boot_open, 1'b1);
    endtask : t_restart
    // Lock query with the host stalled: the first character stands, the
    // buffer fills and input is refused until the line end is queued.
    task automatic t_query(input logic unl, input string s);
        @(negedge clock);
        unlocked = unl;
        sfb_host_model_i.stall = 1'b1;
        sfb_host_model_i.put(sfb_pkg::CH_DISARM);
        sfb_host_model_i.send("");
        repeat (10) @(posedge clock);
        chk(tx_valid, 1'b1);
        chk(tx_data, s[0]);
        chk(rx_ready, 1'b0);
        @(negedge clock);
        sfb_host_model_i.stall = 1'b0;
        reply(s);
    endtask : t_query
    // A torn record, a good one, a bad checksum, then the silent restart.
    task automatic t_load();
        int r;
        int v;
        t_restart();
        sfb_host_model_i.send(":0200");
        t_restart();
        wr.delete();
        sfb_host_model_i.send(":02001000AABB89");
        reply("Ok\015\012");
        chk(wr.size(), 2);
        chk(wr[0], 24'h0010aa);
        chk(wr[1], 24'h0011bb);
        sfb_host_model_i.send(":02002000CCDD34");
        reply("");
        chk(wr.size(), 2);
        r = n_rst;
        v = n_ivl;
        repeat (WIN + 20) @(posedge clock);
        chk(n_rst - r, 1);
        chk(n_ivl - v, 1);
        chk(boot_open, 1'b1);
    endtask : t_load
    // Locked: no write, no answer; idle expiry closes the window quietly.
    task automatic t_locked();
        int r;
        t_restart();
        // A frozen clock enable must hold the window timer still.
        @(negedge clock);
        clk_en = 1'b0;
        repeat (WIN + 10) @(posedge clock);
        chk(boot_open, 1'b1);
        @(negedge clock);
        clk_en = 1'b1;
        t_query(1'b0, "L\015\012");
        wr.delete();
        sfb_host_model_i.send(":02001000AABB89");
        reply("");
        r = n_rst;
        @(negedge clock);
        unlocked = 1'b1;
        repeat (2 * WIN + 20) @(posedge clock);
        chk(boot_open, 1'b0);
        chk(n_rst - r, 0);
        sfb_host_model_i.send(":02001000AABB89");
        reply("");
        chk(wr.size(), 0);
    endtask : t_locked
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // Watchdog: the tests need a few thousand cycles at most.
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        results();
    end
    // Reset for three cycles, then the scenarios in turn.
    initial begin
        resetn   = 1'b0;
        clk_en   = 1'b1;
        unlocked = 1'b1;
        repeat (2) @(negedge clock);
        chk(rx_ready, 1'b0);
        chk(boot_open, 1'b1);
        @(negedge clock);
        resetn = 1'b1;
        t_query(1'b1, "U\015\012");
        t_load();
        t_locked();
        results();
    end
endmodule : serial_firmware_bootloader_tb_top
`default_nettype wire

// ### sim/sfb_host_model.sv
// Host-side model that feeds bytes to the loader and collects its replies.
`default_nettype none
module sfb_host_model (
    // Clock.
    input  wire logic       clock,
    // Byte stream toward the loader.
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready,
    // Reply stream coming back.
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       stall = 1'b0;  // Set by the bench to hold replies back.
    logic [7:0] got[$];        // Reply characters in arrival order.
    ////////////////////////////////////////////////////////////////////////
    // The line starts idle; a slow host simply lowers its ready.
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end
    assign tx_ready = !stall;
    // Every character taken at a rising edge is kept for the bench.
    always @(posedge clock) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Offer one byte and hold it until the loader takes it.
    task automatic put(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clock);
        rx_valid = 1'b1;
        rx_data  = b;
        // Ready is a flop output, so it is read at the falling edge where it
        // has settled; the following rising edge then takes the byte.
        while (!rx_ready && n < 400) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
    endtask : put
    // Send text back to back; the released line shows the inverse byte, so a
    // loader that samples it after release cannot see the old value.
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            put(s[i]);
        end
        @(negedge clock);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask : send
endmodule : sfb_host_model
`default_nettype wire
